// >>> core/ppc_pkg.sv
// Package for the parallel-port configuration register bank.
// Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
`default_nettype none
package ppc_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_LDN  = 8'h07;
  localparam logic [7:0] IDX_ACT  = 8'h30;
  localparam logic [7:0] IDX_RC   = 8'h31;
  localparam logic [7:0] IDX_B1H  = 8'h60;
  localparam logic [7:0] IDX_B1L  = 8'h61;
  localparam logic [7:0] IDX_B2H  = 8'h62;
  localparam logic [7:0] IDX_B2L  = 8'h63;
  localparam logic [7:0] IDX_IRQ  = 8'h70;
  localparam logic [7:0] IDX_ITYP = 8'h71;
  localparam logic [7:0] IDX_DMA  = 8'h74;
  localparam logic [7:0] IDX_SPC  = 8'hF0;
  localparam logic [7:0] IDX_STAT = 8'hF8;
  // Logical device number that selects this bank
  localparam logic [7:0] LDN_PARPORT = 8'h03;
  // Reset values
  localparam logic [7:0] RST_LDN  = 8'h00;
  localparam logic [7:0] RST_ACT  = 8'h00;
  localparam logic [7:0] RST_RC   = 8'h00;
  localparam logic [7:0] RST_B1H  = 8'h03;
  localparam logic [7:0] RST_B1L  = 8'h78;
  localparam logic [7:0] RST_B2H  = 8'h07;
  localparam logic [7:0] RST_B2L  = 8'h78;
  localparam logic [7:0] RST_IRQ  = 8'h07;
  localparam logic [7:0] ITYP_VAL = 8'h02;
  localparam logic [7:0] RST_DMA  = 8'h03;
  localparam logic [7:0] RST_SPC  = 8'h03;
  // Writable bit masks
  localparam logic [7:0] MSK_ACT  = 8'h01;
  localparam logic [7:0] MSK_RC   = 8'h03;
  localparam logic [7:0] MSK_BH   = 8'h0F;
  localparam logic [7:0] MSK_BL   = 8'hFC;
  localparam logic [7:0] MSK_IRQ  = 8'h0F;
  localparam logic [7:0] MSK_DMA  = 8'h07;
  localparam logic [7:0] MSK_SPC  = 8'h07;
  // Field positions
  localparam int ACT_EN_BIT    = 0;
  localparam int RC_PAT_BIT    = 0;
  localparam int RC_EN_BIT     = 1;
  localparam int SPC_EPP_BIT   = 0;
  localparam int SPC_ECP_BIT   = 1;
  localparam int SPC_SHARE_BIT = 2;
  localparam int BL_EPP_BLK    = 2;
  // Range check answers
  localparam logic [7:0] RC_ANS_SET = 8'h55;
  localparam logic [7:0] RC_ANS_CLR = 8'hAA;
  // Interrupt level codes and the host lines they reach
  localparam logic [3:0] IRQ_CODE_3  = 4'h3;
  localparam logic [3:0] IRQ_CODE_11 = 4'hB;
  localparam int IRQ_LINE_3  = 3;
  localparam int IRQ_LINE_11 = 11;
  localparam int NUM_IRQ     = 16;
  localparam int NUM_DMA     = 4;
  localparam logic [2:0] DMA_NONE = 3'h4;
  // Bus widths and responses
  localparam int AXI_AW = 12;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Effective configuration handed to the port logic
  typedef struct packed {
    logic        active;
    logic        rc_on;
    logic [15:0] base1;
    logic [15:0] base2;
    logic [3:0]  irq_sel;
    logic [2:0]  dma_sel;
    logic        irq_share;
    logic        epp_en;
    logic        ecp_en;
  } ppc_cfg_t;
endpackage
`default_nettype wire

// >>> core/ppc_regs.sv
// Parallel-port configuration bank behind an AXI4-Lite slave, with the
// host I/O range decode, range check answer and IRQ/DMA line steering.
// Assumes host I/O strobes synchronous to MCLK and one bus master.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - Bank is selected only while the logical device number is 03h.
// R2 - Activate bit 0 at 30h enables the port; range check off first.
// R3 - Range check enable is bit 1 at 31h; set only while inactive.
// R4 - Range check probes the I/O range programmed as the base address.
// R5 - During range check, reads in range return 55h or AAh by bit 0.
// R6 - Base high registers: bits 7-4 read zero, bits 3-0 hold 11:8.
// R7 - Base low registers: bits 7-2 hold 7:2, bits 1-0 read zero.
// R8 - Second base pair at 62h/63h only acts while ECP is enabled.
// R9 - Interrupt code Bh drives line 11, 3h line 3, others none.
// R10 - Interrupt type at 71h is read-only and returns 02h.
// R11 - DMA code 0-3 picks that channel, 4h none, 5h-7h invalid.
// R12 - Special bit 2 makes the request output shareable.
// R13 - Special bits 1-0 select SPP, EPP, ECP or both.
// R14 - ECP and EPP enable bits act independently.
// R15 - EPP stays off while base1 low bit 2 is set.
// R16 - Special register at F0h resets to 03h.
// R17 - Reserved DMA and special bits 7-3 read zero.
// R18 - Inactive port decodes nothing and drives no IRQ or DMA line; PORT_WIN2 still follows the window decode while inactive.
module ppc_regs
  import ppc_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  RSTN,
  input  wire logic [AXI_AW-1:0]     S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0]     S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire logic [15:0]           IO_ADDR,
  input  wire logic                  IO_RD,
  input  wire logic                  IO_WR,
  output logic                       IO_RC_ACK,
  output logic [7:0]                 IO_RDATA,
  output logic                       PORT_SEL,
  output logic                       PORT_WIN2,
  input  wire logic                  PORT_IRQ,
  input  wire logic                  PORT_DRQ,
  output logic                       PORT_DACK,
  output logic [ppc_pkg::NUM_IRQ-1:0] IRQ_OUT,
  output logic [ppc_pkg::NUM_IRQ-1:0] IRQ_OE,
  output logic [ppc_pkg::NUM_DMA-1:0] DRQ_OUT,
  input  wire logic [ppc_pkg::NUM_DMA-1:0] DACK_N,
  output ppc_pkg::ppc_cfg_t          CFG
);
  import ppc_pkg::*;

  logic [7:0]        ldn_q, act_q, rc_q, b1h_q, b1l_q, b2h_q, b2l_q;
  logic [7:0]        irq_q, dma_q, spc_q;
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic              wr_go, wr_en, pp_wr, sel;
  logic [7:0]        wr_idx, wd;
  logic [7:0]        rd_val;
  logic              rd_err;
  logic              epp_eff, ecp_eff, rc_on, active;
  logic              hit1, hit2, hit;
  logic [15:0]       base1, base2;
  logic [NUM_IRQ-1:0] line_sel;
  logic              rc_ack_q, port_sel_q, win2_q, dack_q;
  logic [7:0]        io_rdata_q;
  logic [NUM_IRQ-1:0] irq_out_q, irq_oe_q;
  logic [NUM_DMA-1:0] drq_q;

  // True when the address lies in the window that starts at base
  function automatic logic in_window(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input logic        wide);
    in_window = wide ? (a[15:3] == b[15:3]) : (a[15:2] == b[15:2]);
  endfunction

  // True when a byte address lies inside the register map (bits above 9 zero)
  function automatic logic idx_ok(input logic [AXI_AW-1:0] a);
    idx_ok = (a[AXI_AW-1:10] == '0);
  endfunction

  // One-hot host request line for an interrupt level code
  function automatic logic [NUM_IRQ-1:0] irq_line(input logic [3:0] c);
    irq_line = '0;
    if (c == IRQ_CODE_11)
      irq_line[IRQ_LINE_11] = 1'b1;
    else if (c == IRQ_CODE_3)
      irq_line[IRQ_LINE_3] = 1'b1;
  endfunction

  // Write path: address and data are caught separately, then committed
  assign wr_go  = aw_have_q & w_have_q;
  assign wr_idx = awaddr_q[9:2];
  assign wd     = wdata_q[7:0];
  assign wr_en  = wr_go & wstrb_q[0] & idx_ok(awaddr_q);
  assign sel    = (ldn_q == LDN_PARPORT); // R1
  assign pp_wr  = wr_en & sel; // R1

  assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // Capture of write address and write data
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  // Write response, raised on the same edge as the commit
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= idx_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_q <= 1'b0;
  end

  // Logical device number selecting which bank the indices reach
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      ldn_q <= RST_LDN;
    else if (wr_en && wr_idx == IDX_LDN)
      ldn_q <= wd;
  end

  // Activate and range check, each refusing the forbidden order
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      act_q <= RST_ACT;
      rc_q  <= RST_RC;
    end
    else if (pp_wr && wr_idx == IDX_ACT)
    begin
      if (!(wd[ACT_EN_BIT] && rc_q[RC_EN_BIT])) // R2
        act_q <= wd & MSK_ACT; // R2
    end
    else if (pp_wr && wr_idx == IDX_RC)
    begin
      rc_q <= wd & MSK_RC;
      if (act_q[ACT_EN_BIT])
        rc_q[RC_EN_BIT] <= 1'b0; // R3
    end
  end

  // Base address pairs; read-only bits are held at zero
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      b1h_q <= RST_B1H;
      b1l_q <= RST_B1L;
      b2h_q <= RST_B2H;
      b2l_q <= RST_B2L;
    end
    else if (pp_wr)
    begin
      if (wr_idx == IDX_B1H)
        b1h_q <= wd & MSK_BH; // R6
      if (wr_idx == IDX_B1L)
        b1l_q <= wd & MSK_BL; // R7
      if (wr_idx == IDX_B2H)
        b2h_q <= wd & MSK_BH; // R6
      if (wr_idx == IDX_B2L)
        b2l_q <= wd & MSK_BL; // R7
    end
  end

  // Interrupt level, DMA channel and special configuration
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_q <= RST_IRQ;
      dma_q <= RST_DMA;
      spc_q <= RST_SPC; // R16
    end
    else if (pp_wr)
    begin
      if (wr_idx == IDX_IRQ)
        irq_q <= wd & MSK_IRQ;
      if (wr_idx == IDX_DMA)
        dma_q <= wd & MSK_DMA; // R17
      if (wr_idx == IDX_SPC)
        spc_q <= wd & MSK_SPC; // R17
    end
  end

  // Read decode of the register map
  always_comb
  begin
    rd_val = 8'h00;
    rd_err = 1'b0;
    if (!idx_ok(S_AXI_ARADDR))
      rd_err = 1'b1;
    else
    begin
      case (S_AXI_ARADDR[9:2])
        IDX_LDN:  rd_val = ldn_q;
        IDX_STAT: rd_val = {5'h00, rc_on, ecp_eff, epp_eff};
        IDX_ACT:  rd_val = sel ? act_q : 8'h00; // R1
        IDX_RC:   rd_val = sel ? rc_q : 8'h00;
        IDX_B1H:  rd_val = sel ? b1h_q : 8'h00;
        IDX_B1L:  rd_val = sel ? b1l_q : 8'h00;
        IDX_B2H:  rd_val = sel ? b2h_q : 8'h00;
        IDX_B2L:  rd_val = sel ? b2l_q : 8'h00;
        IDX_IRQ:  rd_val = sel ? irq_q : 8'h00;
        IDX_ITYP: rd_val = sel ? ITYP_VAL : 8'h00; // R10
        IDX_DMA:  rd_val = sel ? dma_q : 8'h00;
        IDX_SPC:  rd_val = sel ? spc_q : 8'h00;
        default:  rd_err = 1'b1;
      endcase
    end
  end

  // Read channel: one item at a time, answered on the next edge
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_val};
      rresp_q  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  // Effective configuration seen by the port logic
  assign active  = act_q[ACT_EN_BIT];
  assign rc_on   = rc_q[RC_EN_BIT] & ~active; // R4
  assign ecp_eff = spc_q[SPC_ECP_BIT]; // R14
  assign epp_eff = spc_q[SPC_EPP_BIT] & ~b1l_q[BL_EPP_BLK]; // R15
  assign base1   = {b1h_q, b1l_q};
  assign base2   = {b2h_q, b2l_q};
  assign line_sel = irq_line(irq_q[3:0]); // R9

  always_comb
  begin
    CFG.active    = active;
    CFG.rc_on     = rc_on;
    CFG.base1     = base1;
    CFG.base2     = base2;
    CFG.irq_sel   = irq_q[3:0];
    CFG.dma_sel   = dma_q[2:0];
    CFG.irq_share = spc_q[SPC_SHARE_BIT]; // R12
    CFG.epp_en    = epp_eff; // R13
    CFG.ecp_en    = ecp_eff; // R13
  end

  // Host I/O decode: base1 window widens to eight ports under EPP
  assign hit1 = in_window(IO_ADDR, base1, epp_eff);
  assign hit2 = ecp_eff & in_window(IO_ADDR, base2, 1'b0); // R8
  assign hit  = hit1 | hit2;

  // Range check answer and port select, one edge after the strobe
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rc_ack_q   <= 1'b0;
      io_rdata_q <= 8'h00;
      port_sel_q <= 1'b0;
      win2_q     <= 1'b0;
    end
    else
    begin
      rc_ack_q   <= IO_RD & rc_on & hit; // R5
      io_rdata_q <= rc_q[RC_PAT_BIT] ? RC_ANS_SET : RC_ANS_CLR; // R5
      port_sel_q <= (IO_RD | IO_WR) & active & hit; // R18
      win2_q     <= ~hit1 & hit2;
    end
  end

  // Interrupt steering; shared mode drives only while asserting
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_out_q <= '0;
      irq_oe_q  <= '0;
    end
    else
    begin
      irq_out_q <= active ? (line_sel & {NUM_IRQ{PORT_IRQ}}) : '0; // R18
      if (!active)
        irq_oe_q <= '0; // R18
      else if (spc_q[SPC_SHARE_BIT])
        irq_oe_q <= line_sel & {NUM_IRQ{PORT_IRQ}}; // R12
      else
        irq_oe_q <= line_sel; // R9
    end
  end

  // DMA request steering, one flip-flop per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DMA; gi++)
    begin : g_drq
      always_ff @(posedge MCLK or negedge RSTN)
      begin
        if (!RSTN)
          drq_q[gi] <= 1'b0;
        else
          drq_q[gi] <= active & PORT_DRQ & (dma_q[2:0] == 3'(gi)); // R11
      end
    end
  endgenerate

  // Acknowledge back to the port from the selected channel only
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      dack_q <= 1'b0;
    else
      dack_q <= active && dma_q[2:0] < DMA_NONE &&
                !DACK_N[dma_q[1:0]]; // R11
  end

  assign IO_RC_ACK = rc_ack_q;
  assign IO_RDATA  = io_rdata_q;
  assign PORT_SEL  = port_sel_q;
  assign PORT_WIN2 = win2_q;
  assign IRQ_OUT   = irq_out_q;
  assign IRQ_OE    = irq_oe_q;
  assign DRQ_OUT   = drq_q;
  assign PORT_DACK = dack_q;

  // Checks on the configuration behaviour
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_ldn_gates_write: assert property ( // R1
    (wr_en && !sel && wr_idx == IDX_SPC) |=> $stable(spc_q))
    else $error("special register changed while bank not selected");
  a_act_refused: assert property ( // R2
    (pp_wr && wr_idx == IDX_ACT && wd[0] && rc_q[RC_EN_BIT]) |=> !active)
    else $error("port activated with range check on");
  a_rc_refused: assert property ( // R3
    (pp_wr && wr_idx == IDX_RC && active) |=> !rc_q[RC_EN_BIT])
    else $error("range check enabled on an active port");
  a_rc_answer: assert property ( // R5
    (IO_RD && rc_on && hit1) |=> IO_RC_ACK &&
      IO_RDATA == ($past(rc_q[0]) ? 8'h55 : 8'hAA))
    else $error("range check answer wrong");
  a_base_zero_bits: assert property ( // R6
    CFG.base1[15:12] == 4'h0 && CFG.base2[1:0] == 2'b00)
    else $error("read-only base bits not zero");
  a_win2_gated: assert property ( // R8
    (IO_RD && !ecp_eff && !hit1) |=> !IO_RC_ACK && !PORT_SEL)
    else $error("second window decoded without ECP");
  a_irq_map: assert property ( // R9
    (active && irq_q[3:0] == 4'hB && PORT_IRQ) |=> IRQ_OUT[11] && IRQ_OE[11])
    else $error("level Bh did not reach line 11");
  a_itype_read: assert property ( // R10
    (S_AXI_ARVALID && S_AXI_ARREADY && sel &&
     S_AXI_ARADDR == 12'h1C4) |=> S_AXI_RDATA == 32'h00000002)
    else $error("interrupt type read not 02h");
  a_epp_blocked: assert property ( // R15
    b1l_q[2] |-> !CFG.epp_en)
    else $error("EPP enabled with base bit 2 set");
  a_reserved_zero: assert property ( // R17
    dma_q[7:3] == 5'h00 && spc_q[7:3] == 5'h00)
    else $error("reserved bits not zero");
  a_inactive_quiet: assert property ( // R18
    (!active ##1 !active) |-> IRQ_OE == '0 && DRQ_OUT == '0 && !PORT_SEL)
    else $error("inactive port drives lines");

  c_range_check: cover property (IO_RC_ACK && IO_RDATA == 8'h55);
  c_port_select: cover property (PORT_SEL && PORT_WIN2);
  c_shared_irq: cover property (CFG.irq_share && IRQ_OE != '0);
  c_dma_req: cover property (DRQ_OUT[3]);
endmodule
`default_nettype wire

// >>> sim/ppc_port_model.sv
// Far-side model: the parallel port raising its interrupt and DMA
// requests, and the host DMA controller acknowledging them.
// Assumes the bench commands the requests and shares MCLK and RSTN.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_model (
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       irq_want,
  input  wire logic       drq_want,
  input  wire logic [3:0] drq_out,
  output logic            port_irq,
  output logic            port_drq,
  output logic [3:0]      dack_n
);
  // Port requests follow the bench command one edge later
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      port_irq <= 1'h0;
      port_drq <= 1'h0;
    end
    else
    begin
      port_irq <= irq_want;
      port_drq <= drq_want;
    end
  end

  // Host acknowledges only the channel that is requesting
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      dack_n <= 4'hF;
    else
      dack_n <= ~drq_out;
  end
endmodule
`default_nettype wire

// >>> sim/test_parallel_port_pnp_config.sv
// Self-checking bench for the parallel-port configuration bank.
// Assumes ppc_pkg, ppc_regs and ppc_port_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_parallel_port_pnp_config;
  import ppc_pkg::*;
  logic        mclk = 1'h0;
  logic        rstn, awv, wv, bready, arv, rready, io_rd, io_wr;
  logic        irq_want, drq_want, port_irq, port_drq, port_dack;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, rc_ack, sel, win2;
  logic [11:0] aw_addr, ar_addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] io_addr, irq_out, irq_oe, base;
  logic [7:0]  io_rdata, hi, lo;
  logic [3:0]  drq_out, dack_n;
  ppc_cfg_t    cfg;
  logic [32:0] exp_rd[$];
  logic [1:0]  exp_rs[$];
  logic [8:0]  exp_io[$];
  int          bad_count, total_checks;
  logic [7:0]  idx_tab [10] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h62, 8'h63,
                                8'h70, 8'h71, 8'h74, 8'hF0};
  logic [7:0]  rst_tab [10] = '{8'h00, 8'h00, 8'h03, 8'h78, 8'h07, 8'h78,
                                8'h07, 8'h02, 8'h03, 8'h03};
  logic [7:0]  msk_tab [10] = '{8'h00, 8'h00, 8'h0F, 8'hFC, 8'h0F, 8'hFC,
                                8'h0F, 8'h02, 8'h07, 8'h07};

  // 25 MHz clock
  always #20 mclk = ~mclk;

  ppc_regs uut (
    .MCLK(mclk), .RSTN(rstn), .S_AXI_AWADDR(aw_addr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .IO_ADDR(io_addr), .IO_RD(io_rd),
    .IO_WR(io_wr), .IO_RC_ACK(rc_ack), .IO_RDATA(io_rdata),
    .PORT_SEL(sel), .PORT_WIN2(win2), .PORT_IRQ(port_irq),
    .PORT_DRQ(port_drq), .PORT_DACK(port_dack), .IRQ_OUT(irq_out),
    .IRQ_OE(irq_oe), .DRQ_OUT(drq_out), .DACK_N(dack_n), .CFG(cfg)
  );

  ppc_port_model far (
    .MCLK(mclk), .RSTN(rstn), .irq_want(irq_want), .drq_want(drq_want),
    .drq_out(drq_out), .port_irq(port_irq), .port_drq(port_drq),
    .dack_n(dack_n)
  );

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Byte address of a register index
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // One write; byte addresses above the register map (bits 11-10 not zero) expect a slave error.
  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    aw_addr <= a;
    wdata   <= {24'h0, d};
    awv     <= 1'h1;
    wv      <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (awv && awrdy)
        awv <= 1'h0;
      if (wv && wrdy)
        wv <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    chk({31'h0, bresp}, {31'h0, (a[11:10] != 2'h0) ? RESP_SLVERR : RESP_OKAY});
  endtask

  // One read; the expected byte and response are noted for the monitor
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0]  r = RESP_OKAY);
    exp_rd.push_back({25'h0, e});
    exp_rs.push_back(r);
    @(posedge mclk);
    ar_addr <= a;
    arv     <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (arv && arrdy)
        arv <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
  endtask

  // One host I/O strobe, then the port decode is compared
  task automatic io(input logic [15:0] a, input logic w, input logic s);
    @(posedge mclk);
    io_addr <= a;
    io_rd   <= !w;
    io_wr   <= w;
    @(posedge mclk);
    io_rd <= 1'h0;
    io_wr <= 1'h0;
    #1;
    chk({32'h0, sel}, {32'h0, s});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Compare every answer with the oldest noted expectation
  always @(posedge mclk)
  begin
    if (rvalid && rready)
      chk({1'h0, rdata}, exp_rd.size() ? exp_rd.pop_front() : 33'h1FFFFFFFF);
    if (rvalid && rready)
      chk({31'h0, rresp}, {31'h0, exp_rs.size() ? exp_rs.pop_front() : 2'h3});
    if (rc_ack)
      chk({25'h0, io_rdata},
          {24'h0, exp_io.size() ? exp_io.pop_front() : 9'h100});
  end

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    int i;
    {rstn, awv, wv, bready, arv, rready, io_rd, io_wr} = 8'h0;
    {irq_want, drq_want} = 2'h0;
    aw_addr = 12'h0;
    ar_addr = 12'h0;
    wdata = 32'h0;
    io_addr = 16'h0;
    void'($urandom(95));
    repeat (16) @(posedge mclk);
    rstn <= 1'h1;
    // Reset values, write masks, reserved and read-only bits
    rd(ba(IDX_B1H), 8'h00);
    wr(ba(IDX_SPC), 8'h00);
    wr(ba(IDX_LDN), LDN_PARPORT);
    for (i = 0; i < 10; i++)
      rd(ba(idx_tab[i]), rst_tab[i]);
    for (i = 2; i < 10; i++)
    begin
      wr(ba(idx_tab[i]), 8'hFF);
      rd(ba(idx_tab[i]), msk_tab[i]);
    end
    rd(ba(IDX_STAT), 8'h02);
    wr(ba(IDX_B1L), 8'h78);
    for (i = 0; i < 4; i++)
    begin
      wr(ba(IDX_SPC), i[7:0]);
      rd(ba(IDX_STAT), i[7:0]);
    end
    rd(ba(8'h50), 8'h00, RESP_SLVERR);
    wr(12'h400, 8'h00);
    wr(ba(IDX_B2H), 8'h07);
    wr(ba(IDX_B2L), 8'h78);
    // Range check on a random base while inactive
    hi = 8'($urandom % 7);
    lo = 8'($urandom) & 8'hF8;
    base = {4'h0, hi[3:0], lo};
    wr(ba(IDX_B1H), hi);
    wr(ba(IDX_B1L), lo);
    chk({17'h0, cfg.base1}, {17'h0, base});
    wr(ba(IDX_RC), 8'h03);
    wr(ba(IDX_ACT), 8'h01);
    rd(ba(IDX_ACT), 8'h00);
    rd(ba(IDX_STAT), 8'h07);
    exp_io.push_back(9'h055);
    io(base + 16'($urandom % 4), 1'h0, 1'h0);
    wr(ba(IDX_RC), 8'h02);
    exp_io.push_back(9'h0AA);
    io(base, 1'h0, 1'h0);
    io(base + 16'h0010, 1'h0, 1'h0);
    io(base, 1'h1, 1'h0);
    // Active port decodes; range check then refused
    wr(ba(IDX_RC), 8'h00);
    wr(ba(IDX_ACT), 8'h01);
    io(base + 16'h0001, 1'h0, 1'h1);
    io(base, 1'h1, 1'h1);
    wr(ba(IDX_RC), 8'h03);
    rd(ba(IDX_RC), 8'h01);
    wr(ba(IDX_SPC), 8'h02);
    io(16'h0778, 1'h0, 1'h1);
    chk({32'h0, win2}, 33'h1);
    wr(ba(IDX_SPC), 8'h01);
    io(16'h0778, 1'h0, 1'h0);
    // Every interrupt level code, normal output
    wr(ba(IDX_SPC), 8'h00);
    irq_want <= 1'h1;
    for (i = 0; i < 16; i++)
    begin
      wr(ba(IDX_IRQ), i[7:0]);
      settle(3);
      chk({17'h0, irq_oe},
          (i == 3) ? 33'h8 : (i == 11) ? 33'h800 : 33'h0);
      chk({17'h0, irq_out},
          (i == 3) ? 33'h8 : (i == 11) ? 33'h800 : 33'h0);
    end
    // Shared request line drives only while the port asks
    wr(ba(IDX_IRQ), 8'h0B);
    wr(ba(IDX_SPC), 8'h04);
    chk({32'h0, cfg.irq_share}, 33'h1);
    irq_want <= 1'h0;
    settle(3);
    chk({17'h0, irq_oe}, 33'h0);
    irq_want <= 1'h1;
    settle(3);
    chk({17'h0, irq_oe}, 33'h800);
    // Every DMA channel code
    drq_want <= 1'h1;
    for (i = 0; i < 8; i++)
    begin
      wr(ba(IDX_DMA), i[7:0]);
      settle(4);
      chk({29'h0, drq_out}, (i < 4) ? 33'(1 << i) : 33'h0);
      chk({32'h0, port_dack}, (i < 4) ? 33'h1 : 33'h0);
    end
    // Inactive port drives and decodes nothing
    wr(ba(IDX_DMA), 8'h01);
    wr(ba(IDX_ACT), 8'h00);
    settle(4);
    chk({17'h0, irq_oe}, 33'h0);
    chk({29'h0, drq_out}, 33'h0);
    io(base, 1'h0, 1'h0);
    settle(4);
    print_verdict();
  end
endmodule
`default_nettype wire
